/* hw/irq_logic_pkg.sv */
// Purpose: constants, register layout and carrier types of the interrupt logic
// Assumes: one register port with 8-bit address and 8-bit data
// Notes:   bit positions follow the control and option register layouts
package irq_logic_pkg;

    // ------------------------------------------------------------
    // register addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL     = 8'h0b;
    localparam logic [7:0] ADDR_CTRL_HI  = 8'h8b;
    localparam logic [7:0] ADDR_OPTION   = 8'h81;
    localparam logic [7:0] ADDR_AUX      = 8'h07;

    // ------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------
    localparam int BIT_GLOBAL_EN   = 7;
    localparam int BIT_TIMER_EN    = 5;
    localparam int BIT_EXT_EN      = 4;
    localparam int BIT_PORT_EN     = 3;
    localparam int BIT_TIMER_FLAG  = 2;
    localparam int BIT_EXT_FLAG    = 1;
    localparam int BIT_PORT_FLAG   = 0;
    // option and auxiliary register fields
    localparam int BIT_EDGE_SELECT = 6;
    localparam int BIT_EE_FLAG     = 0;
    localparam int BIT_EE_EN       = 1;

    // ------------------------------------------------------------
    // source indices and reset values
    // ------------------------------------------------------------
    localparam int NUM_SOURCES = 4;
    localparam int SRC_PORT    = 0;
    localparam int SRC_EXT     = 1;
    localparam int SRC_TIMER   = 2;
    localparam int SRC_EE      = 3;

    localparam logic [7:0]  CTRL_RESET   = 8'h00;
    localparam logic [7:0]  OPTION_RESET = 8'hff;
    localparam logic [7:0]  TIMER_MAX    = 8'hff;
    localparam logic [7:0]  TIMER_ZERO   = 8'h00;
    localparam logic [12:0] IRQ_VECTOR   = 13'h0004;

    // ------------------------------------------------------------
    // sequencer states, gray along idle-sync-push-vector
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SYNC = 2'b01,
        ST_PUSH = 2'b11,
        ST_VECT = 2'b10
    } seq_state_type;

    // ------------------------------------------------------------
    // carriers to and from the processor core
    // ------------------------------------------------------------
    typedef struct packed {
        logic instr_boundary;
        logic sleep_active;
        logic return_from_irq;
    } core_status_type;

    typedef struct packed {
        logic        push_return;
        logic        pop_return;
        logic        vector_load;
        logic        wake;
        logic [12:0] vector_addr;
    } core_cmd_type;

endpackage

/* hw/mcu_interrupt_logic.sv */
// Purpose: interrupt flags, masking, vectoring and sleep wake-up for a small core
// Assumes: clk is the instruction cycle; pins and core inputs are synchronous
// Notes:   one register port; read data appear only in the cycle after the read
//
// Chosen here: strobed register access and the register offsets.
`timescale 1ns/10ps
`default_nettype none

module mcu_interrupt_logic
    import irq_logic_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [7:0]       reg_addr,
    input  wire logic [7:0]       reg_wdata,
    input  wire logic             reg_write,
    input  wire logic             reg_read,
    output logic      [7:0]       reg_rdata,
    input  wire logic             ext_irq_pin,
    input  wire logic [3:0]       upper_port,
    input  wire logic [7:0]       timer_counter,
    input  wire logic             ee_write_done,
    input  wire core_status_type  core_status,
    output core_cmd_type          core_cmd
);

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic [NUM_SOURCES-1:0] flag_reg;
    logic [NUM_SOURCES-1:0] enable_reg;
    logic                   global_irq_enable_reg;
    logic [7:0]             option_reg;
    logic                   ext_pin_reg;
    logic [3:0]             port_prev_reg;
    logic [7:0]             timer_prev_reg;
    logic                   sleep_prev_reg;
    logic                   ext_en_sleep_reg;
    seq_state_type          state_reg;
    seq_state_type          state_next;
    logic [7:0]             rdata_next;

    logic                   wr_ctrl;
    logic                   wr_option;
    logic                   wr_aux;
    logic [NUM_SOURCES-1:0] event_vec;
    logic [NUM_SOURCES-1:0] sw_flag_val;
    logic [NUM_SOURCES-1:0] sw_en_val;
    logic [NUM_SOURCES-1:0] wr_src;
    logic                   ext_edge;
    logic                   ext_irq_flag;
    logic                   ext_edge_select;
    logic                   irq_req;
    logic                   wake_cond;
    logic                   take_irq;

    assign wr_ctrl   = reg_write && (reg_addr == ADDR_CTRL || reg_addr == ADDR_CTRL_HI);
    assign wr_option = reg_write && (reg_addr == ADDR_OPTION);
    assign wr_aux    = reg_write && (reg_addr == ADDR_AUX);

    assign ext_edge_select = option_reg[BIT_EDGE_SELECT];
    assign ext_irq_flag    = flag_reg[SRC_EXT];

    // ------------------------------------------------------------
    // event detection
    // ------------------------------------------------------------
    // sampled during reset too, so a pin held away from zero shows no false edge at release
    always_ff @(posedge clk)
    begin
        ext_pin_reg    <= ext_irq_pin;
        port_prev_reg  <= upper_port;
        timer_prev_reg <= timer_counter;
    end

    // rising when edge select set, falling otherwise
    assign ext_edge = ext_edge_select ? (ext_irq_pin && !ext_pin_reg)
                                      : (!ext_irq_pin && ext_pin_reg);

    // source events; the timer cannot count while the core sleeps
    always_comb
    begin
        event_vec            = '0;
        event_vec[SRC_EXT]   = ext_edge;
        event_vec[SRC_PORT]  = |(upper_port ^ port_prev_reg);
        event_vec[SRC_TIMER] = !core_status.sleep_active &&
                               timer_prev_reg == TIMER_MAX &&
                               timer_counter == TIMER_ZERO;
        event_vec[SRC_EE]    = ee_write_done;
    end

    // ------------------------------------------------------------
    // software view of flags and enables per source
    // ------------------------------------------------------------
    always_comb
    begin
        sw_flag_val            = '0;
        sw_en_val              = '0;
        wr_src                 = '0;
        sw_flag_val[SRC_PORT]  = reg_wdata[BIT_PORT_FLAG];
        sw_flag_val[SRC_EXT]   = reg_wdata[BIT_EXT_FLAG];
        sw_flag_val[SRC_TIMER] = reg_wdata[BIT_TIMER_FLAG];
        sw_flag_val[SRC_EE]    = reg_wdata[BIT_EE_FLAG];
        sw_en_val[SRC_PORT]    = reg_wdata[BIT_PORT_EN];
        sw_en_val[SRC_EXT]     = reg_wdata[BIT_EXT_EN];
        sw_en_val[SRC_TIMER]   = reg_wdata[BIT_TIMER_EN];
        sw_en_val[SRC_EE]      = reg_wdata[BIT_EE_EN];
        wr_src[SRC_PORT]       = wr_ctrl;
        wr_src[SRC_EXT]        = wr_ctrl;
        wr_src[SRC_TIMER]      = wr_ctrl;
        wr_src[SRC_EE]         = wr_aux;
    end

    // ------------------------------------------------------------
    // sticky flags, set wins over a software clear
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < NUM_SOURCES; gi = gi + 1)
        begin : g_src
            always_ff @(posedge clk)
            begin
                if (!rst_n)
                begin
                    flag_reg[gi]   <= 1'b0;
                    enable_reg[gi] <= 1'b0;
                end
                else
                begin
                    if (event_vec[gi])
                        flag_reg[gi] <= 1'b1;
                    else if (wr_src[gi])
                        flag_reg[gi] <= sw_flag_val[gi];
                    if (wr_src[gi])
                        enable_reg[gi] <= sw_en_val[gi];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // global enable and option register
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            global_irq_enable_reg <= CTRL_RESET[BIT_GLOBAL_EN];
        else if (take_irq)
            global_irq_enable_reg <= 1'b0;
        else if (core_status.return_from_irq)
            global_irq_enable_reg <= 1'b1;
        else if (wr_ctrl)
            global_irq_enable_reg <= reg_wdata[BIT_GLOBAL_EN];
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            option_reg <= OPTION_RESET;
        else if (wr_option)
            option_reg <= reg_wdata;
    end

    // ------------------------------------------------------------
    // request to the core
    // ------------------------------------------------------------
    assign irq_req = global_irq_enable_reg && |(flag_reg & enable_reg);

    // ------------------------------------------------------------
    // sleep wake-up
    // ------------------------------------------------------------
    // pin enable is caught as sleep begins; later changes do not count
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            sleep_prev_reg   <= 1'b0;
            ext_en_sleep_reg <= 1'b0;
        end
        else
        begin
            sleep_prev_reg <= core_status.sleep_active;
            if (core_status.sleep_active && !sleep_prev_reg)
                ext_en_sleep_reg <= enable_reg[SRC_EXT];
        end
    end

    // global enable plays no part here
    assign wake_cond = core_status.sleep_active && sleep_prev_reg &&
                       ((ext_irq_flag && ext_en_sleep_reg) ||
                        (flag_reg[SRC_PORT] && enable_reg[SRC_PORT]) ||
                        (flag_reg[SRC_EE] && enable_reg[SRC_EE]));

    // ------------------------------------------------------------
    // vectoring sequencer
    // ------------------------------------------------------------
    // an aligned request pushes at once, otherwise it waits one cycle
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE:
            begin
                if (irq_req && !core_status.sleep_active)
                    state_next = core_status.instr_boundary ? ST_PUSH : ST_SYNC;
            end
            ST_SYNC: state_next = ST_PUSH;
            ST_PUSH: state_next = ST_VECT;
            ST_VECT: state_next = ST_IDLE;
            default: state_next = ST_IDLE;
        endcase
    end

    assign take_irq = (state_reg == ST_IDLE) && (state_next != ST_IDLE);

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            state_reg <= ST_IDLE;
        else
            state_reg <= state_next;
    end

    // ------------------------------------------------------------
    // core command outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            core_cmd <= '0;
        else
        begin
            core_cmd.push_return <= (state_next == ST_PUSH);
            core_cmd.vector_load <= (state_next == ST_VECT);
            core_cmd.vector_addr <= IRQ_VECTOR;
            core_cmd.pop_return  <= core_status.return_from_irq;
            core_cmd.wake        <= wake_cond;
        end
    end

    // ------------------------------------------------------------
    // register read port
    // ------------------------------------------------------------
    always_comb
    begin
        rdata_next = 8'h00;
        if (reg_read)
        begin
            case (reg_addr)
                ADDR_CTRL, ADDR_CTRL_HI:
                begin
                    rdata_next[BIT_GLOBAL_EN]  = global_irq_enable_reg;
                    rdata_next[BIT_TIMER_EN]   = enable_reg[SRC_TIMER];
                    rdata_next[BIT_EXT_EN]     = enable_reg[SRC_EXT];
                    rdata_next[BIT_PORT_EN]    = enable_reg[SRC_PORT];
                    rdata_next[BIT_TIMER_FLAG] = flag_reg[SRC_TIMER];
                    rdata_next[BIT_EXT_FLAG]   = flag_reg[SRC_EXT];
                    rdata_next[BIT_PORT_FLAG]  = flag_reg[SRC_PORT];
                end
                ADDR_OPTION: rdata_next = option_reg;
                ADDR_AUX:
                begin
                    rdata_next[BIT_EE_FLAG] = flag_reg[SRC_EE];
                    rdata_next[BIT_EE_EN]   = enable_reg[SRC_EE];
                end
                default: rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            reg_rdata <= 8'h00;
        else
            reg_rdata <= rdata_next;
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence s_pin_request;
        $rose(ext_irq_flag) && global_irq_enable_reg && enable_reg[SRC_EXT] &&
        state_reg == ST_IDLE && !core_status.sleep_active;
    endsequence
    sequence s_vector_issue;
        core_cmd.push_return ##1 core_cmd.vector_load;
    endsequence
    a_reset_gie_off: assert property (
        @(posedge clk) !$past(rst_n) && rst_n |-> !global_irq_enable_reg)
        else $error("global enable not clear after reset");
    a_latency_window: assert property (
        @(posedge clk) disable iff (!rst_n)
        s_pin_request |-> ##[1:2] s_vector_issue)
        else $error("vector not reached in three to four cycles");
    a_take_clears_gie: assert property (
        @(posedge clk) disable iff (!rst_n)
        core_cmd.push_return |-> !global_irq_enable_reg ##1
            (core_cmd.vector_load && core_cmd.vector_addr == IRQ_VECTOR))
        else $error("take did not clear enable or load vector 0004h");
    a_return_sets_gie: assert property (
        @(posedge clk) disable iff (!rst_n)
        core_status.return_from_irq && !take_irq |=>
            global_irq_enable_reg && core_cmd.pop_return)
        else $error("return did not re-enable or pop");
    a_edge_sets_flag: assert property (
        @(posedge clk) disable iff (!rst_n)
        $changed(ext_irq_pin) && (ext_irq_pin == ext_edge_select) |=> ext_irq_flag)
        else $error("valid pin edge missed");
    a_wrong_edge_quiet: assert property (
        @(posedge clk) disable iff (!rst_n)
        !ext_irq_flag && !wr_ctrl && $changed(ext_irq_pin) &&
            (ext_irq_pin != ext_edge_select) |=> !ext_irq_flag)
        else $error("flag set on the wrong edge");
    a_timer_wrap_flag: assert property (
        @(posedge clk) disable iff (!rst_n)
        !core_status.sleep_active && $past(timer_counter) == TIMER_MAX &&
            timer_counter == TIMER_ZERO |=> flag_reg[SRC_TIMER])
        else $error("timer wrap did not set flag");

    a_port_change_flag: assert property (
        @(posedge clk) disable iff (!rst_n)
        upper_port != $past(upper_port) |=> flag_reg[SRC_PORT])
        else $error("port change did not set flag");

    a_flag_sticky: assert property (
        @(posedge clk) disable iff (!rst_n)
        flag_reg[SRC_TIMER] && !wr_ctrl |=> flag_reg[SRC_TIMER])
        else $error("flag dropped without a write");

    a_gie_blocks_all: assert property (
        @(posedge clk) disable iff (!rst_n)
        state_reg == ST_IDLE && !global_irq_enable_reg |=> state_reg == ST_IDLE)
        else $error("vectoring started with global enable clear");

    a_masked_no_take: assert property (
        @(posedge clk) disable iff (!rst_n)
        state_reg == ST_IDLE && !(|(flag_reg & enable_reg)) |=> state_reg == ST_IDLE)
        else $error("vectoring started with all sources masked");

    a_sleep_wake: assert property (
        @(posedge clk) disable iff (!rst_n)
        core_status.sleep_active && sleep_prev_reg && ((flag_reg[SRC_PORT] && enable_reg[SRC_PORT]) ||
            (flag_reg[SRC_EE] && enable_reg[SRC_EE])) |=> core_cmd.wake)
        else $error("enabled flag did not wake the core");
endmodule

`default_nettype wire

/* verification/irq_core_model.sv */
// Purpose: behavioural core sequencer facing the interrupt logic
// Assumes: one instruction-cycle clock, requests from the bench by one-cycle pulses
// Notes:   slow mode makes two-cycle instructions, so boundaries come every other cycle
`timescale 1ns/10ps
`default_nettype none

module irq_core_model
    import irq_logic_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         slow,
    input  wire logic         sleep_req,
    input  wire logic         ret_req,
    input  wire core_cmd_type core_cmd,
    output core_status_type   core_status
);
    logic phase_reg;
    logic sleep_reg;
    logic ret_reg;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            phase_reg <= 1'b0;
        else
            phase_reg <= ~phase_reg;
    end

    // a wake command ends sleep; the core then resumes in line
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            sleep_reg <= 1'b0;
        else if (core_cmd.wake)
            sleep_reg <= 1'b0;
        else if (sleep_req)
            sleep_reg <= 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            ret_reg <= 1'b0;
        else
            ret_reg <= ret_req;
    end

    assign core_status = {(slow ? phase_reg : 1'b1), sleep_reg, ret_reg};
endmodule

`default_nettype wire

/* verification/mcu_interrupt_logic_tb_top.sv */
// Purpose: self-checking bench of the interrupt logic
// Assumes: core model supplies boundary, sleep and return signals
// Notes:   one task per scenario; expectations come from package constants and literal register values
`timescale 1ns/10ps
`default_nettype none
`define CHECK(got, exp) begin n_compared++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end

module mcu_interrupt_logic_tb_top
    import irq_logic_pkg::*;
;
    logic            clk = 1'b0;
    logic            rst_n = 1'b0;
    logic            reg_write = 1'b0;
    logic            reg_read = 1'b0;
    logic [7:0]      reg_addr = 8'h00;
    logic [7:0]      reg_wdata = 8'h00;
    logic [7:0]      reg_rdata;
    logic            ext_irq_pin = 1'b0;
    logic [3:0]      upper_port = 4'h0;
    logic [7:0]      timer_counter = 8'h00;
    logic            ee_write_done = 1'b0;
    logic            slow = 1'b0;
    logic            sleep_req = 1'b0;
    logic            ret_req = 1'b0;
    core_status_type core_status;
    core_cmd_type    core_cmd;
    int              n_mismatch = 0;
    int              n_compared = 0;

    always #20 clk = ~clk;

    mcu_interrupt_logic u_mcu_interrupt_logic (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .ext_irq_pin(ext_irq_pin), .upper_port(upper_port), .timer_counter(timer_counter),
        .ee_write_done(ee_write_done), .core_status(core_status), .core_cmd(core_cmd));

    irq_core_model u_irq_core_model (.clk(clk), .rst_n(rst_n), .slow(slow), .sleep_req(sleep_req),
        .ret_req(ret_req), .core_cmd(core_cmd), .core_status(core_status));

    // ------------------------------------------------------------
    // bus and wait helpers
    // ------------------------------------------------------------
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask

    task automatic reg_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1;
        `CHECK(reg_rdata, exp)
    endtask

    task automatic no_take(input int n);
        repeat (n)
        begin
            @(posedge clk);
            #1;
            `CHECK(core_cmd.push_return, 1'b0)
        end
    endtask

    // counts cycles from the current one until the vector load
    task automatic expect_take(output int lat);
        lat = 0;
        do
        begin
            @(posedge clk);
            #1;
            lat++;
        end
        while (core_cmd.push_return !== 1'b1 && lat < 6);
        `CHECK(core_cmd.push_return, 1'b1)
        @(posedge clk);
        #1;
        lat++;
        `CHECK(core_cmd.vector_load, 1'b1)
        `CHECK(core_cmd.vector_addr, IRQ_VECTOR)
    endtask

    task automatic expect_wake(input logic exp);
        int n;
        n = 0;
        do
        begin
            @(posedge clk);
            #1;
            n++;
        end
        while (core_cmd.wake !== 1'b1 && n < 5);
        `CHECK(core_cmd.wake, exp)
    endtask

    task automatic enter_sleep();
        @(posedge clk);
        sleep_req <= 1'b1;
        @(posedge clk);
        sleep_req <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        #1;
        `CHECK(core_cmd, {4'h0, IRQ_VECTOR})
        reg_chk(ADDR_CTRL, CTRL_RESET);
        reg_chk(ADDR_CTRL_HI, CTRL_RESET);
        reg_chk(ADDR_OPTION, OPTION_RESET);
        reg_chk(ADDR_AUX, 8'h00);
        reg_chk(8'h55, 8'h00);
    endtask

    task automatic t_ext(input logic sl, input logic rise);
        int lat;
        @(posedge clk);
        slow        <= sl;
        ext_irq_pin <= ~rise;
        reg_wr(ADDR_OPTION, rise ? 8'hff : 8'hbf);
        reg_wr(ADDR_CTRL, 8'h90);
        @(posedge clk);
        ext_irq_pin <= rise;
        expect_take(lat);
        `CHECK(lat == 3 || lat == 4, 1'b1)
        reg_chk(ADDR_CTRL, 8'h12);
        reg_wr(ADDR_CTRL, 8'h10);
        @(posedge clk);
        ret_req <= 1'b1;
        @(posedge clk);
        ret_req <= 1'b0;
        @(posedge clk);
        #1;
        `CHECK(core_cmd.pop_return, 1'b1)
        reg_chk(ADDR_CTRL, 8'h90);
    endtask

    task automatic t_masked();
        int         lat;
        logic [7:0] en [3] = '{8'h10, 8'h20, 8'h08};
        reg_wr(ADDR_OPTION, 8'hff);
        reg_wr(ADDR_CTRL, 8'h38);
        @(posedge clk);
        timer_counter <= 8'hff;
        ext_irq_pin   <= 1'b0;
        @(posedge clk);
        timer_counter <= 8'h00;
        upper_port    <= 4'ha;
        ext_irq_pin   <= 1'b1;
        no_take(4);
        reg_chk(ADDR_CTRL, 8'h3f);
        reg_wr(ADDR_CTRL, 8'h87);
        no_take(4);
        for (int i = 0; i < 3; i++)
        begin
            reg_wr(ADDR_CTRL, 8'h87 | en[i]);
            expect_take(lat);
            reg_wr(ADDR_CTRL, 8'h07);
        end
    endtask

    task automatic t_sleep();
        @(posedge clk);
        ext_irq_pin <= 1'b0;
        reg_wr(ADDR_CTRL, 8'h10);
        enter_sleep();
        ext_irq_pin <= 1'b1;
        expect_wake(1'b1);
        no_take(4);
        reg_chk(ADDR_CTRL, 8'h12);
        reg_wr(ADDR_CTRL, 8'h00);
        @(posedge clk);
        ext_irq_pin <= 1'b0;
        enter_sleep();
        reg_wr(ADDR_CTRL, 8'h10);
        @(posedge clk);
        ext_irq_pin <= 1'b1;
        expect_wake(1'b0);
        reg_wr(ADDR_AUX, 8'h02);
        @(posedge clk);
        ee_write_done <= 1'b1;
        @(posedge clk);
        ee_write_done <= 1'b0;
        expect_wake(1'b1);
        reg_chk(ADDR_AUX, 8'h03);
    endtask

    task automatic t_second_reset();
        reg_wr(ADDR_AUX, 8'h00);
        reg_wr(ADDR_CTRL_HI, 8'h80);
        reg_chk(ADDR_CTRL, 8'h80);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        reg_chk(ADDR_CTRL, CTRL_RESET);
        reg_chk(ADDR_AUX, 8'h00);
    endtask

    task automatic finish_test();
        $display("comparisons %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial
    begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset();
        t_ext(1'b0, 1'b1);
        t_ext(1'b1, 1'b0);
        t_masked();
        t_sleep();
        t_second_reset();
        finish_test();
    end

    // the scenarios need well under a thousand cycles
    initial
    begin
        #(5000 * 40);
        n_mismatch++;
        finish_test();
    end
endmodule

`default_nettype wire
